// File: src/analog_channel_postproc_image.sv
`timescale 1ns/1ps
module analog_channel_postproc_image (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cycle_tick,
  input wire logic [255:0] raw_values,
  input wire logic [15:0] over_range,
  input wire logic [15:0] under_range,
  input wire logic [15:0] cm_exceeded,
  input wire logic [15:0] low_voltage,
  input wire logic [1:0] img_sub,
  input wire logic [5:0] img_byte,
  output logic [7:0] input_image_byte,
  output logic [1:0] mains_select,
  output logic [15:0] diag_overflow,
  output logic [15:0] diag_underflow,
  output logic [15:0] diag_common_mode,
  output logic [15:0] diag_wire_break,
  output logic [31:0] hw_irq_pulse,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int N = chan_pkg::NUM_CH;

  // Window decodes; config and limit windows shared by write and read paths so they never disagree
  function automatic logic in_cfg_win(input logic [11:0] a);
    in_cfg_win = (a[11:6] == chan_pkg::CH_CFG_BASE[11:6]);
  endfunction

  function automatic logic in_lim_win(input logic [11:0] a);
    in_lim_win = (a[11:8] == chan_pkg::LIM_BASE[11:8]);
  endfunction

  function automatic logic in_img_win(input logic [11:0] a);
    in_img_win = (a[11:6] == chan_pkg::IMAGE_BASE[11:6]);
  endfunction

  // ==========================================================================
  // Configuration registers
  logic [1:0] cfg_mode_q;
  logic [1:0] mains_q;
  logic basic_ready_q;
  logic [11:0] ch_cfg_q [N];
  logic [15:0] hi1_q [N];
  logic [15:0] lo1_q [N];
  logic [15:0] hi2_q [N];
  logic [15:0] lo2_q [N];
  logic status_on;
  logic wr_en;
  logic rd_en;
  logic [3:0] wch;
  logic [1:0] wsel;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign wch = paddr[5:2];
  assign wsel = paddr[7:6];
  // Status bits exist in both non-plain configurations
  assign status_on = (cfg_mode_q != chan_pkg::CFG_PLAIN);

  // Global configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_mode_q <= chan_pkg::CFG_PLAIN;
      mains_q <= chan_pkg::MAINS_RST;
      basic_ready_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == chan_pkg::CFG_MODE_ADDR && pwdata[1:0] != 2'h3) begin
        cfg_mode_q <= pwdata[1:0];
      end
      if (paddr == chan_pkg::CFG_MAINS_ADDR) begin
        mains_q <= pwdata[1:0];
      end
      if (paddr == chan_pkg::BASIC_READY_ADDR) begin
        basic_ready_q <= pwdata[0];
      end
    end
  end

  // Per-channel configuration and the two limit sets
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        ch_cfg_q[i] <= 12'h000;
        hi1_q[i] <= chan_pkg::HI_LIMIT_RST;
        lo1_q[i] <= chan_pkg::LO_LIMIT_RST;
        hi2_q[i] <= chan_pkg::HI_LIMIT_RST;
        lo2_q[i] <= chan_pkg::LO_LIMIT_RST;
      end
    end else if (wr_en) begin
      if (in_cfg_win(paddr)) begin
        ch_cfg_q[wch] <= pwdata[11:0];
      end
      if (in_lim_win(paddr)) begin
        unique case (wsel)
          2'h0: hi1_q[wch] <= pwdata[15:0];
          2'h1: lo1_q[wch] <= pwdata[15:0];
          2'h2: hi2_q[wch] <= pwdata[15:0];
          2'h3: lo2_q[wch] <= pwdata[15:0];
        endcase
      end
    end
  end

  assign mains_select = mains_q;

  // ==========================================================================
  // Sample stage: raw value and condition flags, taken once per module cycle
  logic [15:0] smoothed [N];
  logic [15:0] value_q [N];
  logic [15:0] valid_q;
  logic [15:0] wb_act;

  // Wire break check only meaningful in the 1-5 V range
  always_comb begin
    for (int i = 0; i < N; i++) begin
      wb_act[i] = ch_cfg_q[i][chan_pkg::F_WB_EN]
        && ch_cfg_q[i][chan_pkg::F_RANGE_LSB +: 2] == chan_pkg::RNG_1TO5;
    end
  end

  // Codes stand in for a fault only when neither wire break nor status shows it
  logic [15:0] code_ok;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      code_ok[i] = !wb_act[i] && !status_on;
    end
  end

  // Diagnostics latch per module cycle so all outputs agree with the image
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      diag_overflow <= 16'h0000;
      diag_underflow <= 16'h0000;
      diag_common_mode <= 16'h0000;
      diag_wire_break <= 16'h0000;
    end else if (cycle_tick) begin
      for (int i = 0; i < N; i++) begin
        diag_overflow[i] <= ch_cfg_q[i][chan_pkg::F_OVF_EN] && over_range[i];
        diag_underflow[i] <= ch_cfg_q[i][chan_pkg::F_UDF_EN] && under_range[i];
        diag_common_mode[i] <= ch_cfg_q[i][chan_pkg::F_CM_EN] && cm_exceeded[i];
        diag_wire_break[i] <= wb_act[i] && low_voltage[i];
      end
    end
  end

  // ==========================================================================
  // Smoothing and limit monitoring, one smoother and two limit pairs per channel
  logic limit_tick_q;

  // Limit stage runs one cycle behind the tick, on the freshly published value
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      limit_tick_q <= 1'b0;
    end else begin
      limit_tick_q <= cycle_tick;
    end
  end

  for (genvar g = 0; g < N; g++) begin : g_ch
    chan_smoother u_smooth (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(cycle_tick),
      .level(ch_cfg_q[g][chan_pkg::F_SMOOTH_LSB +: 2]),
      .raw(raw_values[g*16 +: 16]),
      .smoothed(smoothed[g])
    );
    limit_detect u_lim1 (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(limit_tick_q),
      .value(value_q[g]),
      .hi_lim(hi1_q[g]),
      .lo_lim(lo1_q[g]),
      .hi_en(ch_cfg_q[g][chan_pkg::F_HI1_EN]),
      .lo_en(ch_cfg_q[g][chan_pkg::F_LO1_EN]),
      .fire(hw_irq_pulse[g])
    );
    limit_detect u_lim2 (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(limit_tick_q),
      .value(value_q[g]),
      .hi_lim(hi2_q[g]),
      .lo_lim(lo2_q[g]),
      .hi_en(ch_cfg_q[g][chan_pkg::F_HI2_EN]),
      .lo_en(ch_cfg_q[g][chan_pkg::F_LO2_EN]),
      .fire(hw_irq_pulse[N + g])
    );
  end

  // ==========================================================================
  // Published channel value and validity
  // Any fault condition spoils validity; a too-low input is a wiring fault
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q <= 16'h0000;
    end else if (cycle_tick) begin
      valid_q <= ~(over_range | under_range | cm_exceeded | low_voltage);
    end
  end

  // Fault codes replace the value only when nothing else reports the fault
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        value_q[i] <= 16'h0000;
      end
    end else if (cycle_tick) begin
      for (int i = 0; i < N; i++) begin
        if (code_ok[i] && (over_range[i] || low_voltage[i])) begin
          value_q[i] <= chan_pkg::OVF_CODE;
        end else if (code_ok[i] && under_range[i]) begin
          value_q[i] <= chan_pkg::UDF_CODE;
        end else begin
          value_q[i] <= smoothed[i];
        end
      end
    end
  end

  // ==========================================================================
  // Input image read port, start-relative byte offsets
  logic [15:0] sub_status;
  logic [7:0] img_d;
  logic sub_ok;

  // Image bytes for the selected submodule
  always_comb begin
    sub_ok = (img_sub == 2'h0)
      || (cfg_mode_q == chan_pkg::CFG_SHARED);
    // Basic submodule: valid only; copies also need basic ready
    if (img_sub == 2'h0) begin
      sub_status = valid_q;
    end else begin
      sub_status = basic_ready_q ? valid_q : 16'h0000;
    end
    img_d = 8'h00;
    if (!sub_ok) begin
      img_d = 8'h00;
    end else if (img_byte < chan_pkg::STATUS_LO_OFS) begin
      // Big-endian pair at twice the channel number
      img_d = img_byte[0] ? value_q[img_byte[4:1]][7:0]
        : value_q[img_byte[4:1]][15:8];
    end else if (status_on && img_byte == chan_pkg::STATUS_LO_OFS) begin
      img_d = sub_status[7:0];
    end else if (status_on && img_byte == chan_pkg::STATUS_HI_OFS) begin
      img_d = sub_status[15:8];
    end
  end

  // Registered so the image byte is a data output
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      input_image_byte <= 8'h00;
    end else begin
      input_image_byte <= img_d;
    end
  end

  // ==========================================================================
  // APB slave: zero wait, unmapped reads give zero with pslverr
  logic [31:0] rd_d;
  logic hit;

  always_comb begin
    rd_d = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == chan_pkg::CFG_MODE_ADDR) begin
      rd_d = {30'h0, cfg_mode_q};
    end else if (paddr == chan_pkg::CFG_MAINS_ADDR) begin
      rd_d = {30'h0, mains_q};
    end else if (paddr == chan_pkg::BASIC_READY_ADDR) begin
      rd_d = {31'h0, basic_ready_q};
    end else if (paddr == chan_pkg::SAMPLE_ADDR) begin
      rd_d = {16'h0, valid_q};
    end else if (paddr == chan_pkg::DIAG_STAT_ADDR) begin
      rd_d = {diag_wire_break | diag_common_mode, diag_overflow | diag_underflow};
    end else if (paddr == chan_pkg::HW_IRQ_ADDR) begin
      rd_d = hw_irq_pulse;
    end else if (in_cfg_win(paddr)) begin
      rd_d = {20'h0, ch_cfg_q[wch]};
    end else if (in_lim_win(paddr)) begin
      unique case (wsel)
        2'h0: rd_d = {16'h0, hi1_q[wch]};
        2'h1: rd_d = {16'h0, lo1_q[wch]};
        2'h2: rd_d = {16'h0, hi2_q[wch]};
        2'h3: rd_d = {16'h0, lo2_q[wch]};
      endcase
    end else if (in_img_win(paddr)) begin
      rd_d = {16'h0, value_q[wch]};
    end else begin
      hit = 1'b0;
    end
  end

  // Read data captured on the setup-phase edge, before penable rises
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit && rd_en;
endmodule // analog_channel_postproc_image

// File: src/chan_pkg.sv
package chan_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_CH = 16;
  localparam int NUM_SUB = 4;
  localparam int VAL_W = 16;
  localparam int IMG_BYTES = 34;
  localparam logic [5:0] STATUS_LO_OFS = 6'h20;
  localparam logic [5:0] STATUS_HI_OFS = 6'h21;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] CFG_MODE_ADDR = 12'h000;
  localparam logic [11:0] CFG_MAINS_ADDR = 12'h004;
  localparam logic [11:0] BASIC_READY_ADDR = 12'h008;
  localparam logic [11:0] SAMPLE_ADDR = 12'h00c;
  localparam logic [11:0] DIAG_STAT_ADDR = 12'h010;
  localparam logic [11:0] HW_IRQ_ADDR = 12'h014;
  localparam logic [11:0] CH_CFG_BASE = 12'h100;
  localparam logic [11:0] LIM_BASE = 12'h200;
  localparam logic [11:0] IMAGE_BASE = 12'h400;
  localparam logic [11:0] RAW_BASE = 12'h800;

  // ==========================================================================
  // Channel config field positions (CH_CFG word)
  localparam int F_OVF_EN = 0;
  localparam int F_UDF_EN = 1;
  localparam int F_CM_EN = 2;
  localparam int F_WB_EN = 3;
  localparam int F_HI1_EN = 4;
  localparam int F_LO1_EN = 5;
  localparam int F_HI2_EN = 6;
  localparam int F_LO2_EN = 7;
  localparam int F_RANGE_LSB = 8;
  localparam int F_SMOOTH_LSB = 10;

  // ==========================================================================
  // Modes, ranges, smoothing
  typedef enum logic [1:0] {
    CFG_PLAIN = 2'h0, CFG_STATUS = 2'h1, CFG_SHARED = 2'h2
  } cfg_mode_t;
  typedef enum logic [1:0] {
    RNG_PM10 = 2'h0, RNG_PM5 = 2'h1, RNG_1TO5 = 2'h2, RNG_PM1 = 2'h3
  } range_t;
  typedef enum logic [1:0] {
    SM_NONE = 2'h0, SM_WEAK = 2'h1, SM_MEDIUM = 2'h2, SM_STRONG = 2'h3
  } smooth_t;

  localparam logic [15:0] OVF_CODE = 16'h7fff;
  localparam logic [15:0] UDF_CODE = 16'h8000;
  localparam logic [15:0] HI_LIMIT_RST = 16'h6c00;
  localparam logic [15:0] LO_LIMIT_RST = 16'h9400;
  localparam logic [1:0] MAINS_RST = 2'h1;

  // Shift for k = 1, 4, 16, 32
  function automatic logic [2:0] smooth_shift(input logic [1:0] lvl);
    case (lvl)
      2'h0: smooth_shift = 3'h0;
      2'h1: smooth_shift = 3'h2;
      2'h2: smooth_shift = 3'h4;
      default: smooth_shift = 3'h5;
    endcase
  endfunction

endpackage

// File: src/chan_smoother.sv
`timescale 1ns/1ps
// ============================================================================
// First-order filter, one channel, updated once per module cycle
module chan_smoother (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic [1:0] level,
  input wire logic signed [15:0] raw,
  output logic signed [15:0] smoothed
);
  logic signed [23:0] acc_q;
  logic signed [23:0] acc_d;
  logic signed [24:0] gap;
  logic signed [24:0] diff;
  logic [2:0] sh;

  // Fixed-point accumulator keeps 8 fraction bits so strong smoothing still settles
  // Guard bit and signed operands: a full-scale falling step must shift arithmetically
  always_comb begin
    sh = chan_pkg::smooth_shift(level);
    gap = $signed({raw[15], raw, 8'h00}) - $signed({acc_q[23], acc_q});
    diff = gap >>> sh;
    if (sh == 3'h0) begin
      acc_d = {raw, 8'h00};
    end else if (diff == 25'sh0000000 && acc_q[23:8] != raw) begin
      acc_d = {raw, 8'h00}; // Final snap avoids a permanent residue
    end else begin
      acc_d = acc_q + diff[23:0];
    end
  end

  // Step toward input by 1/k per cycle; k = 1 copies at once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= 24'sh000000;
    end else if (tick) begin
      acc_q <= acc_d;
    end
  end

  // Value after this tick's step, so the tick that samples raw also publishes it
  assign smoothed = acc_d[23:8];
endmodule // chan_smoother

// File: src/limit_detect.sv
`timescale 1ns/1ps
// ============================================================================
// One limit pair: edge-only interrupt pulses on entering violation
module limit_detect (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic signed [15:0] value,
  input wire logic signed [15:0] hi_lim,
  input wire logic signed [15:0] lo_lim,
  input wire logic hi_en,
  input wire logic lo_en,
  output logic fire
);
  logic hi_in_q;
  logic lo_in_q;
  logic hi_now;
  logic lo_now;

  assign hi_now = hi_en && (value > hi_lim);
  assign lo_now = lo_en && (value < lo_lim);

  // Armed flags: a limit fires once, rearms only after return inside
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_in_q <= 1'b0;
      lo_in_q <= 1'b0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (tick) begin
        hi_in_q <= hi_now;
        lo_in_q <= lo_now;
        fire <= (hi_now && !hi_in_q) || (lo_now && !lo_in_q);
      end
    end
  end
endmodule // limit_detect

// File: tb/chan_postproc_props.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checks for the channel post-processing block
module chan_postproc_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cycle_tick,
  input wire logic [15:0] over_range,
  input wire logic [15:0] under_range,
  input wire logic [15:0] low_voltage,
  input wire logic [1:0] img_sub,
  input wire logic [5:0] img_byte,
  input wire logic [7:0] input_image_byte,
  input wire logic [1:0] mains_select,
  input wire logic [15:0] diag_overflow,
  input wire logic [15:0] diag_underflow,
  input wire logic [15:0] diag_wire_break,
  input wire logic [31:0] hw_irq_pulse,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Mode mirror; code 3 is refused so it never lands here
  logic [1:0] mode_q;
  logic [1:0] wsel;
  logic wr;
  assign wsel = pwdata[1:0];
  assign wr = psel && penable && pwrite;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= 2'h0;
    end else if (wr && paddr == chan_pkg::CFG_MODE_ADDR && wsel != 2'h3) begin
      mode_q <= wsel;
    end
  end
  // ==========================================================================
  // A flag needs its condition at the tick that set it
  property p_ovf;
    $past(cycle_tick) |-> (diag_overflow & ~$past(over_range)) == 16'h0;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag without cause");
  property p_udf;
    $past(cycle_tick) |-> (diag_underflow & ~$past(under_range)) == 16'h0;
  endproperty
  a_udf: assert property (p_udf) else $error("underflow flag without cause");
  property p_wb;
    $past(cycle_tick) |-> (diag_wire_break & ~$past(low_voltage)) == 16'h0;
  endproperty
  a_wb: assert property (p_wb) else $error("wire break flag without cause");
  property p_mains;
    wr && paddr == chan_pkg::CFG_MAINS_ADDR |=> mains_select == $past(wsel);
  endproperty
  a_mains: assert property (p_mains) else $error("mains choice not taken");
  // Pulses come two edges after a tick and never stretch
  property p_irq_at;
    |hw_irq_pulse |-> $past(cycle_tick, 2);
  endproperty
  a_irq_at: assert property (p_irq_at) else $error("interrupt off the tick");
  property p_irq_once;
    |hw_irq_pulse |=> (hw_irq_pulse & $past(hw_irq_pulse)) == 32'h0;
  endproperty
  a_irq_once: assert property (p_irq_once) else $error("interrupt repeated");
  // Image bytes that the mode hides must read zero
  property p_sub;
    $past(mode_q) != chan_pkg::CFG_SHARED && $past(img_sub) != 2'h0 |-> input_image_byte == 8'h0;
  endproperty
  a_sub: assert property (p_sub) else $error("extra submodule visible");
  property p_plain;
    $past(mode_q) == chan_pkg::CFG_PLAIN && $past(img_byte) >= 6'h20 |-> input_image_byte == 8'h0;
  endproperty
  a_plain: assert property (p_plain) else $error("status byte in plain mode");
  c_irq: cover property (|hw_irq_pulse);
  c_wb: cover property (|diag_wire_break);
  c_shared: cover property ($past(mode_q) == chan_pkg::CFG_SHARED && $past(img_sub) != 2'h0);
endmodule // chan_postproc_props

bind analog_channel_postproc_image chan_postproc_props u_props (
  .clk(clk), .sys_rst(sys_rst), .cycle_tick(cycle_tick), .over_range(over_range),
  .under_range(under_range), .low_voltage(low_voltage), .img_sub(img_sub),
  .img_byte(img_byte), .input_image_byte(input_image_byte), .mains_select(mains_select),
  .diag_overflow(diag_overflow), .diag_underflow(diag_underflow),
  .diag_wire_break(diag_wire_break), .hw_irq_pulse(hw_irq_pulse), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
);

// File: tb/io_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================================
// IO controller reading the input image, one byte per access
module io_ctrl_model (
  input wire logic clk,
  output logic [1:0] img_sub,
  output logic [5:0] img_byte,
  input wire logic [7:0] input_image_byte
);
  initial begin
    img_sub = 2'h0;
    img_byte = 6'h0;
  end
  // Address held two edges so the registered byte has landed
  task automatic rd(input logic [1:0] s, input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    img_sub <= s;
    img_byte <= a;
    repeat (2) @(posedge clk);
    d = input_image_byte;
  endtask
endmodule // io_ctrl_model

// File: tb/tb_analog_channel_postproc_image.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench with a behavioural model of the channel image
module tb_analog_channel_postproc_image;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tick = 1'b0;
  logic [255:0] raw = 256'h0;
  logic [15:0] ovr = 16'h0, udr = 16'h0, cmx = 16'h0, lv = 16'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, irq, r, hit = 32'h0;
  logic [15:0] d_ov, d_ud, d_cm, d_wb, eo, eu, ec, ew, wbm, v;
  logic [7:0] ib, b;
  logic [1:0] img_sub, mains;
  logic [5:0] img_byte;
  logic pready, pslverr, e, rdy;
  logic [31:0] cfg[16];
  logic [15:0] tv[8] = '{16'h7000, 16'h7000, 16'h0, 16'h00ff, 16'h6c00, 16'h6c01, 16'h00ff,
    16'h8000};
  int ex_q[$] = '{1, 0, 1, 0, 0, 1, 1, 0};
  int mismatches = 0, n_tests = 0, cyc = 0, np = 0, n0, mode, k, ch;

  always #4 clk = ~clk;

  analog_channel_postproc_image DUT (
    .clk(clk), .sys_rst(sys_rst), .cycle_tick(tick), .raw_values(raw),
    .over_range(ovr), .under_range(udr), .cm_exceeded(cmx), .low_voltage(lv),
    .img_sub(img_sub), .img_byte(img_byte), .input_image_byte(ib),
    .mains_select(mains), .diag_overflow(d_ov), .diag_underflow(d_ud),
    .diag_common_mode(d_cm), .diag_wire_break(d_wb), .hw_irq_pulse(irq),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  io_ctrl_model io (.clk(clk), .img_sub(img_sub), .img_byte(img_byte), .input_image_byte(ib));

  // ==========================================================================
  // Pulse tally and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    np <= np + $countones(irq);
    hit <= hit | irq;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask

  // APB transfer; an idle edge follows so results have landed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask

  // Module cycle; ticks stay well apart
  task automatic tk();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic rdv(input int s, input int c, output logic [15:0] q);
    logic [7:0] hi, lo;
    io.rd(2'(s), 6'(2 * c), hi);
    io.rd(2'(s), 6'(2 * c + 1), lo);
    q = {hi, lo};
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(5));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    chk(mains, 2'h1);
    for (int m = 0; m < 4; m++) begin
      wr(chan_pkg::CFG_MAINS_ADDR, m);
      chk(mains, m);
      apb(1'b0, chan_pkg::CFG_MAINS_ADDR, 32'h0, r, e);
      chk(r, m);
    end
    apb(1'b0, 12'h0f0, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 1'b1);
    // Random enables and ranges, then random conditions
    for (int c = 0; c < 16; c++) begin
      cfg[c] = $urandom & 32'h30f;
      wbm[c] = cfg[c][3] && cfg[c][9:8] == 2'h2;
      wr(chan_pkg::CH_CFG_BASE + 12'(4 * c), cfg[c]);
    end
    repeat (4) begin
      {ovr, udr} <= $urandom;
      {cmx, lv} <= $urandom;
      tk();
      for (int c = 0; c < 16; c++) begin
        eo[c] = cfg[c][0] & ovr[c];
        eu[c] = cfg[c][1] & udr[c];
        ec[c] = cfg[c][2] & cmx[c];
        ew[c] = wbm[c] & lv[c];
      end
      chk(d_ov, eo);
      chk(d_ud, eu);
      chk(d_cm, ec);
      chk(d_wb, ew);
      apb(1'b0, chan_pkg::DIAG_STAT_ADDR, 32'h0, r, e);
      chk(r, {ew | ec, eo | eu});
    end
    // Every mode, ready off and on, all four submodules
    for (int md = 0; md < 3; md++) begin
      mode = md;
      wr(chan_pkg::CFG_MODE_ADDR, md);
      wr(chan_pkg::CFG_MODE_ADDR, 32'h3);
      {ovr, udr} <= 32'h0;
      for (int rr = 0; rr < 2; rr++) begin
        rdy = rr[0];
        wr(chan_pkg::BASIC_READY_ADDR, rr);
        for (int c = 0; c < 16; c++) raw[16*c +: 16] <= 16'($urandom);
        cmx <= 16'($urandom);
        lv <= 16'($urandom) & ~wbm;
        tk();
        apb(1'b0, chan_pkg::SAMPLE_ADDR, 32'h0, r, e);
        chk(r, {16'h0, ~(cmx | lv)});
        for (int s = 0; s < 4; s++) begin
          for (int c = 0; c < 16; c++) begin
            rdv(s, c, v);
            chk(v, (s != 0 && mode != 2) ? 16'h0 : (mode == 0 && lv[c]) ? 16'h7fff :
                raw[16*c +: 16]);
          end
          for (int h = 0; h < 2; h++) begin
            io.rd(2'(s), 6'h20 + 6'(h), b);
            chk(b, (mode == 0 || (s != 0 && !(mode == 2 && rdy))) ? 8'h0 :
                8'(~(cmx | lv) >> (8 * h)));
          end
        end
      end
    end
    // Step response for weak, medium and strong smoothing
    ch = $urandom % 16;
    for (int l = 1; l < 4; l++) begin
      k = (l == 3) ? 32 : 1 << (2 * l);
      wr(chan_pkg::CH_CFG_BASE + 12'(4 * ch), 32'h0);
      raw[16*ch +: 16] <= 16'h0;
      tk();
      wr(chan_pkg::CH_CFG_BASE + 12'(4 * ch), l << chan_pkg::F_SMOOTH_LSB);
      raw[16*ch +: 16] <= 16'h4000;
      tk();
      rdv(0, ch, v);
      chk(v < 16'h4000, 1'b1);
      repeat (k - 1) tk();
      rdv(0, ch, v);
      chk(v >= 16'h2000, 1'b1);
      repeat (7 * k) tk();
      rdv(0, ch, v);
      chk(16'h4000 - v <= 16'h0100, 1'b1);
      // Falling full-scale step exercises the signed path
      raw[16*ch +: 16] <= 16'hc000;
      repeat (8 * k) tk();
      rdv(0, ch, v);
      chk(16'(v - 16'hc000) <= 16'h0100, 1'b1);
    end
    // Set 1 watches high limit, set 2 a written low limit
    wr(chan_pkg::LIM_BASE + 12'(192 + 4 * ch), 32'h100);
    wr(chan_pkg::CH_CFG_BASE + 12'(4 * ch), 32'h90);
    for (int i = 0; i < 8; i++) begin
      raw[16*ch +: 16] <= tv[i];
      n0 = np;
      tk();
      chk(np - n0, ex_q.pop_front());
    end
    chk(hit, (32'h1 << ch) | (32'h1 << (16 + ch)));
    conclude();
  end
endmodule // tb_analog_channel_postproc_image
